// ===== hw/prcw_pkg.sv
// prcw_pkg: widths, codes and counts shared by both ends of the
// analog channel settings writer.
// assumes: both ends run on one reconfiguration clock.
`default_nettype none
package prcw_pkg;
    // =====================================================
    // setting field widths, fixed whatever the channel count
    localparam int SWING_W  = 3;
    localparam int PREEMP_W = 5;
    localparam int DCGAIN_W = 2;
    localparam int EQ_W     = 4;
    localparam int RATE_W   = 4;
    // =====================================================
    // direction select codes and bit positions
    localparam logic [1:0] DIR_NONE = 2'h0;
    localparam logic [1:0] DIR_RX   = 2'h1;
    localparam logic [1:0] DIR_TX   = 2'h2;
    localparam logic [1:0] DIR_BOTH = 2'h3;
    localparam int DIR_RX_BIT = 0;
    localparam int DIR_TX_BIT = 1;
    // =====================================================
    // reset values of channel state
    localparam logic [SWING_W-1:0]  SWING_RST  = 3'h0;
    localparam logic [PREEMP_W-1:0] PREEMP_RST = 5'h00;
    localparam logic [DCGAIN_W-1:0] DCGAIN_RST = 2'h0;
    localparam logic [EQ_W-1:0]     EQ_RST     = 4'h0;
    localparam logic [RATE_W-1:0]   RATE_RST   = 4'h0;
    // =====================================================
    // timing: clock cycles a transfer into a channel takes
    localparam int XFER_CYCLES = 4;
endpackage : prcw_pkg
`default_nettype wire

// ===== hw/prcw_if.sv
// prcw_if: control ports between user logic and the settings writer.
// assumes: both modports on the same clock; no tristate signals.
`default_nettype none
interface prcw_if #(
    parameter int AW = 2
);
    logic [AW-1:0]                chan_addr;
    logic [1:0]                   dir_sel;
    logic                         write_strobe;
    logic [prcw_pkg::SWING_W-1:0]  swing;
    logic [prcw_pkg::PREEMP_W-1:0] preemp;
    logic [prcw_pkg::DCGAIN_W-1:0] dcgain;
    logic [prcw_pkg::EQ_W-1:0]     eq;
    logic                         pll_wr;
    logic [prcw_pkg::RATE_W-1:0]   pll_rate;
    logic                         busy;
    logic [prcw_pkg::SWING_W-1:0]  swing_out;
    logic [prcw_pkg::PREEMP_W-1:0] preemp_out;
    logic [prcw_pkg::DCGAIN_W-1:0] dcgain_out;
    logic [prcw_pkg::EQ_W-1:0]     eq_out;

    modport ctrl (
        input  chan_addr, dir_sel, write_strobe, swing, preemp, dcgain, eq,
        input  pll_wr, pll_rate,
        output busy, swing_out, preemp_out, dcgain_out, eq_out
    );
    modport user (
        output chan_addr, dir_sel, write_strobe, swing, preemp, dcgain, eq,
        output pll_wr, pll_rate,
        input  busy, swing_out, preemp_out, dcgain_out, eq_out
    );
endinterface : prcw_if
`default_nettype wire

// ===== hw/prcw_user.sv
// prcw_user: user-side driver that sequences one settings write.
// assumes: prcw_ctrl on the same clock, so busy needs no synchroniser.
`default_nettype none
module prcw_user #(
    parameter int AW = 2
) (
    input  wire logic                         clock,
    input  wire logic                         rstn,
    prcw_if.user                              bus,
    input  wire logic                         req,
    input  wire logic [AW-1:0]                req_addr,
    input  wire logic [1:0]                   req_dir,
    input  wire logic [prcw_pkg::SWING_W-1:0]  req_swing,
    input  wire logic [prcw_pkg::PREEMP_W-1:0] req_preemp,
    input  wire logic [prcw_pkg::DCGAIN_W-1:0] req_dcgain,
    input  wire logic [prcw_pkg::EQ_W-1:0]     req_eq,
    input  wire logic                         rate_req,
    input  wire logic [prcw_pkg::RATE_W-1:0]   rate_val,
    input  wire logic                         rate_ok,
    output logic                              ready_q,
    output logic                              done_q,
    output logic                              rate_rej_q
);
    // =====================================================
    // sequencer
    typedef enum logic [2:0] {
        PRCW_IDLE, PRCW_SETUP, PRCW_STROBE, PRCW_WAIT
    } prcw_state_type;

    prcw_state_type state_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= PRCW_IDLE;
        end else begin
            case (state_q)
                PRCW_IDLE:   if (req) state_q <= PRCW_SETUP;
                PRCW_SETUP:  if (!bus.busy) state_q <= PRCW_STROBE;
                PRCW_STROBE: state_q <= PRCW_WAIT;
                PRCW_WAIT:   if (!bus.busy) state_q <= PRCW_IDLE;
                default:     state_q <= PRCW_IDLE;
            endcase
        end
    end

    // =====================================================
    // values and index stand from setup until the next request
    logic [AW-1:0]                addr_q;
    logic [1:0]                   dir_q;
    logic [prcw_pkg::SWING_W-1:0]  swing_q;
    logic [prcw_pkg::PREEMP_W-1:0] preemp_q;
    logic [prcw_pkg::DCGAIN_W-1:0] dcgain_q;
    logic [prcw_pkg::EQ_W-1:0]     eq_q;
    logic                         strobe_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            addr_q   <= '0;
            dir_q    <= prcw_pkg::DIR_NONE;
            swing_q  <= prcw_pkg::SWING_RST;
            preemp_q <= prcw_pkg::PREEMP_RST;
            dcgain_q <= prcw_pkg::DCGAIN_RST;
            eq_q     <= prcw_pkg::EQ_RST;
        end else if (state_q == PRCW_IDLE && req) begin
            swing_q  <= req_swing;
            preemp_q <= req_preemp;
            dcgain_q <= req_dcgain;
            eq_q     <= req_eq;
            addr_q   <= req_addr;
            dir_q    <= req_dir;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            strobe_q <= 1'b0;
        end else begin
            // high only for the single cycle spent in strobe state
            strobe_q <= (state_q == PRCW_SETUP) && !bus.busy;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ready_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            ready_q <= (state_q == PRCW_IDLE) && !req;
            done_q  <= (state_q == PRCW_WAIT) && !bus.busy;
        end
    end

    // =====================================================
    // rate change is only forwarded when the mode accepts it
    logic                       pll_wr_q;
    logic [prcw_pkg::RATE_W-1:0] pll_rate_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pll_wr_q   <= 1'b0;
            pll_rate_q <= prcw_pkg::RATE_RST;
            rate_rej_q <= 1'b0;
        end else begin
            pll_wr_q   <= rate_req && rate_ok;
            rate_rej_q <= rate_req && !rate_ok;
            if (rate_req && rate_ok) pll_rate_q <= rate_val;
        end
    end

    assign bus.chan_addr    = addr_q;
    assign bus.dir_sel      = dir_q;
    assign bus.swing        = swing_q;
    assign bus.preemp       = preemp_q;
    assign bus.dcgain       = dcgain_q;
    assign bus.eq           = eq_q;
    assign bus.write_strobe = strobe_q;
    assign bus.pll_wr       = pll_wr_q;
    assign bus.pll_rate     = pll_rate_q;
endmodule : prcw_user
`default_nettype wire

// ===== hw/prcw_ctrl.sv
// prcw_ctrl: writes analog settings into one addressed channel of
// several, plus receive fifo read clock select and shared pll rate.
// assumes: user logic on the same clock drives prcw_if.ctrl.
`default_nettype none
module prcw_ctrl #(
    parameter int NUM_CH      = 4,
    parameter int XFER_CYCLES = prcw_pkg::XFER_CYCLES,
    parameter int AW          = (NUM_CH > 1) ? $clog2(NUM_CH) : 1
) (
    input  wire logic                                     clock,
    input  wire logic                                     rstn,
    prcw_if.ctrl                                          bus,
    input  wire logic                                     rclk_opt,
    output logic [NUM_CH-1:0][prcw_pkg::SWING_W-1:0]      ch_swing_q,
    output logic [NUM_CH-1:0][prcw_pkg::PREEMP_W-1:0]     ch_preemp_q,
    output logic [NUM_CH-1:0][prcw_pkg::DCGAIN_W-1:0]     ch_dcgain_q,
    output logic [NUM_CH-1:0][prcw_pkg::EQ_W-1:0]         ch_eq_q,
    output logic [NUM_CH-1:0][prcw_pkg::RATE_W-1:0]       ch_rate_q,
    output logic [NUM_CH-1:0]                             ch_fifo_own_clk_q
);
    localparam int CW = $clog2(XFER_CYCLES + 1);
    localparam logic [CW-1:0] LAST_CNT = CW'(XFER_CYCLES - 1);

    // =====================================================
    // transfer sequencer
    typedef enum logic [1:0] {
        PRCW_IDLE, PRCW_XFER
    } prcw_state_type;

    prcw_state_type state_q;
    logic [CW-1:0]  cnt_q;
    logic           busy_q;
    logic           start;
    logic           last;

    // a strobe seen while busy is dropped, not queued
    assign start = bus.write_strobe && (state_q == PRCW_IDLE);
    assign last  = (state_q == PRCW_XFER) && (cnt_q == LAST_CNT);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= PRCW_IDLE;
        end else begin
            case (state_q)
                PRCW_IDLE: if (start) state_q <= PRCW_XFER;
                PRCW_XFER: if (last) state_q <= PRCW_IDLE;
                default:   state_q <= PRCW_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= '0;
        end else if (state_q == PRCW_XFER) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            busy_q <= 1'b0;
        end else if (start) begin
            busy_q <= 1'b1;
        end else if (last) begin
            busy_q <= 1'b0;
        end
    end

    // =====================================================
    // request capture
    logic [AW-1:0]                tgt_q;
    logic [1:0]                   dir_q;
    logic [prcw_pkg::SWING_W-1:0]  swing_q;
    logic [prcw_pkg::PREEMP_W-1:0] preemp_q;
    logic [prcw_pkg::DCGAIN_W-1:0] dcgain_q;
    logic [prcw_pkg::EQ_W-1:0]     eq_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tgt_q    <= '0;
            dir_q    <= prcw_pkg::DIR_NONE;
            swing_q  <= prcw_pkg::SWING_RST;
            preemp_q <= prcw_pkg::PREEMP_RST;
            dcgain_q <= prcw_pkg::DCGAIN_RST;
            eq_q     <= prcw_pkg::EQ_RST;
        end else if (start) begin
            // single channel: the index input is not looked at
            tgt_q    <= (NUM_CH > 1) ? bus.chan_addr : '0;
            dir_q    <= bus.dir_sel;
            swing_q  <= bus.swing;
            preemp_q <= bus.preemp;
            dcgain_q <= bus.dcgain;
            eq_q     <= bus.eq;
        end
    end

    // =====================================================
    // per-channel settings storage
    logic wr_tx;
    logic wr_rx;

    // channel state changes in the same edge that drops busy
    assign wr_tx = last && dir_q[prcw_pkg::DIR_TX_BIT];
    assign wr_rx = last && dir_q[prcw_pkg::DIR_RX_BIT];

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic hit;
            // out-of-range index selects no channel
            assign hit = (NUM_CH == 1) || (tgt_q == AW'(g));

            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    ch_swing_q[g]  <= prcw_pkg::SWING_RST;
                    ch_preemp_q[g] <= prcw_pkg::PREEMP_RST;
                end else if (wr_tx && hit) begin
                    ch_swing_q[g]  <= swing_q;
                    ch_preemp_q[g] <= preemp_q;
                end
            end

            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    ch_dcgain_q[g] <= prcw_pkg::DCGAIN_RST;
                    ch_eq_q[g]     <= prcw_pkg::EQ_RST;
                end else if (wr_rx && hit) begin
                    ch_dcgain_q[g] <= dcgain_q;
                    ch_eq_q[g]     <= eq_q;
                end
            end

            // rate comes from the shared pll; nothing else is touched
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    ch_rate_q[g] <= prcw_pkg::RATE_RST;
                end else if (bus.pll_wr) begin
                    ch_rate_q[g] <= bus.pll_rate;
                end
            end

            // select only; the clock mux itself sits in the channel
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    ch_fifo_own_clk_q[g] <= 1'b0;
                end else begin
                    ch_fifo_own_clk_q[g] <= rclk_opt;
                end
            end
        end
    endgenerate

    // =====================================================
    // readback of the channel last addressed
    logic [prcw_pkg::SWING_W-1:0]  rb_swing_q;
    logic [prcw_pkg::PREEMP_W-1:0] rb_preemp_q;
    logic [prcw_pkg::DCGAIN_W-1:0] rb_dcgain_q;
    logic [prcw_pkg::EQ_W-1:0]     rb_eq_q;
    logic [AW-1:0]                 rb_idx;

    // guards a stale index above the channel count
    assign rb_idx = (32'(tgt_q) < NUM_CH) ? tgt_q : '0;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rb_swing_q  <= prcw_pkg::SWING_RST;
            rb_preemp_q <= prcw_pkg::PREEMP_RST;
        end else begin
            rb_swing_q  <= ch_swing_q[rb_idx];
            rb_preemp_q <= ch_preemp_q[rb_idx];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rb_dcgain_q <= prcw_pkg::DCGAIN_RST;
            rb_eq_q     <= prcw_pkg::EQ_RST;
        end else begin
            rb_dcgain_q <= ch_dcgain_q[rb_idx];
            rb_eq_q     <= ch_eq_q[rb_idx];
        end
    end

    assign bus.busy       = busy_q;
    assign bus.swing_out  = rb_swing_q;
    assign bus.preemp_out = rb_preemp_q;
    assign bus.dcgain_out = rb_dcgain_q;
    assign bus.eq_out     = rb_eq_q;
endmodule : prcw_ctrl
`default_nettype wire

// ===== verif/prcw_monitor.sv
// prcw_monitor: concurrent checks on the control ports of the settings writer.
// assumes: one clock; instantiated beside prcw_if with its signals as inputs.
`default_nettype none
module prcw_monitor #(
    parameter int AW = 2
) (
    input wire logic                          clock,
    input wire logic                          rstn,
    input wire logic [AW-1:0]                 chan_addr,
    input wire logic [1:0]                    dir_sel,
    input wire logic                          write_strobe,
    input wire logic [prcw_pkg::SWING_W-1:0]  swing,
    input wire logic [prcw_pkg::PREEMP_W-1:0] preemp,
    input wire logic [prcw_pkg::DCGAIN_W-1:0] dcgain,
    input wire logic [prcw_pkg::EQ_W-1:0]     eq,
    input wire logic                          busy,
    input wire logic [prcw_pkg::SWING_W-1:0]  swing_out,
    input wire logic [prcw_pkg::PREEMP_W-1:0] preemp_out,
    input wire logic [prcw_pkg::DCGAIN_W-1:0] dcgain_out,
    input wire logic [prcw_pkg::EQ_W-1:0]     eq_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // values taken with the last accepted strobe
    logic [1:0]                    dir_q;
    logic [prcw_pkg::SWING_W-1:0]  sw_q;
    logic [prcw_pkg::PREEMP_W-1:0] pe_q;
    logic [prcw_pkg::DCGAIN_W-1:0] dg_q;
    logic [prcw_pkg::EQ_W-1:0]     eq_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dir_q <= 2'h0;
            sw_q  <= 3'h0;
            pe_q  <= 5'h00;
            dg_q  <= 2'h0;
            eq_q  <= 4'h0;
        end else if (write_strobe && !busy) begin
            dir_q <= dir_sel;
            sw_q  <= swing;
            pe_q  <= preemp;
            dg_q  <= dcgain;
            eq_q  <= eq;
        end
    end
    // ==========================================
    // handshake and readback
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    a_busy_start: assert property (write_strobe && !busy |=> busy)
        else $error("busy did not rise after an accepted strobe");
    a_busy_length: assert property ($rose(busy) |-> busy [*4] ##1 !busy)
        else $error("busy length differs from the transfer time");
    a_busy_cause: assert property ($rose(busy) |-> $past(write_strobe))
        else $error("busy rose without a strobe");
    a_reset_idle: assert property ($rose(rstn) |-> !busy)
        else $error("busy high right after reset");
    a_strobe_single: assert property (write_strobe |=> !write_strobe)
        else $error("strobe longer than one clock");
    a_strobe_idle: assert property (write_strobe |-> !busy)
        else $error("strobe while busy");
    a_values_ready: assert property (write_strobe |-> $stable(chan_addr) && $stable(dir_sel)
        && $stable(swing) && $stable(preemp) && $stable(dcgain) && $stable(eq))
        else $error("index or values changed with the strobe");
    a_tx_readback: assert property ($fell(busy) |=> !dir_q[1] || (swing_out == sw_q && preemp_out == pe_q))
        else $error("transmit readback differs from written values");
    a_rx_readback: assert property ($fell(busy) |=> !dir_q[0] || (dcgain_out == dg_q && eq_out == eq_q))
        else $error("receive readback differs from written values");
endmodule : prcw_monitor
`default_nettype wire

// ===== verif/testbench.sv
// testbench: drives the user end of the settings writer, checks both ends.
// assumes: prcw_ctrl with four channels and prcw_user joined by prcw_if.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NCH = 4;
    logic                                   clock, rstn, req, rate_req, rate_ok, rclk_opt;
    logic                                   ready_q, done_q, rate_rej_q;
    logic [1:0]                             req_addr, req_dir;
    logic [2:0]                             req_sw;
    logic [4:0]                             req_pe;
    logic [1:0]                             req_dg;
    logic [3:0]                             req_eq, rate_val;
    logic [NCH-1:0][prcw_pkg::SWING_W-1:0]  ch_sw;
    logic [NCH-1:0][prcw_pkg::PREEMP_W-1:0] ch_pe;
    logic [NCH-1:0][prcw_pkg::DCGAIN_W-1:0] ch_dg;
    logic [NCH-1:0][prcw_pkg::EQ_W-1:0]     ch_eq;
    logic [NCH-1:0][prcw_pkg::RATE_W-1:0]   ch_rate;
    logic [NCH-1:0]                         ch_own;
    logic [2:0]                             x_sw [NCH];
    logic [4:0]                             x_pe [NCH];
    logic [1:0]                             x_dg [NCH];
    logic [3:0]                             x_eq [NCH];
    int                                     fail_count = 0;
    int                                     n_tests = 0;

    prcw_if #(.AW(2)) bus_i ();
    prcw_ctrl #(.NUM_CH(NCH), .XFER_CYCLES(prcw_pkg::XFER_CYCLES), .AW(2)) u_prcw_ctrl (.clock(clock),
        .rstn(rstn), .bus(bus_i), .rclk_opt(rclk_opt), .ch_swing_q(ch_sw), .ch_preemp_q(ch_pe),
        .ch_dcgain_q(ch_dg), .ch_eq_q(ch_eq), .ch_rate_q(ch_rate), .ch_fifo_own_clk_q(ch_own));
    prcw_user #(.AW(2)) u_prcw_user (.clock(clock), .rstn(rstn), .bus(bus_i), .req(req), .req_addr(req_addr),
        .req_dir(req_dir), .req_swing(req_sw), .req_preemp(req_pe), .req_dcgain(req_dg), .req_eq(req_eq),
        .rate_req(rate_req), .rate_val(rate_val), .rate_ok(rate_ok), .ready_q(ready_q), .done_q(done_q),
        .rate_rej_q(rate_rej_q));
    prcw_monitor #(.AW(2)) u_prcw_monitor (.clock(clock), .rstn(rstn), .chan_addr(bus_i.chan_addr),
        .dir_sel(bus_i.dir_sel), .write_strobe(bus_i.write_strobe), .swing(bus_i.swing), .preemp(bus_i.preemp),
        .dcgain(bus_i.dcgain), .eq(bus_i.eq), .busy(bus_i.busy), .swing_out(bus_i.swing_out),
        .preemp_out(bus_i.preemp_out), .dcgain_out(bus_i.dcgain_out), .eq_out(bus_i.eq_out));

    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_chans;
        for (int i = 0; i < NCH; i++) begin
            check({ch_sw[i], ch_pe[i]}, {x_sw[i], x_pe[i]});
            check({ch_dg[i], ch_eq[i]}, {x_dg[i], x_eq[i]});
        end
    endtask : check_chans

    // one write through the user end; counts busy cycles on the way
    task automatic do_write(input logic [1:0] a, input logic [1:0] d, input logic [2:0] s,
                            input logic [4:0] p, input logic [1:0] g, input logic [3:0] e);
        int nb;
        nb = 0;
        @(posedge clock);
        req      <= 1'b1;
        req_addr <= a;
        req_dir  <= d;
        req_sw   <= s;
        req_pe   <= p;
        req_dg   <= g;
        req_eq   <= e;
        @(posedge clock);
        req <= 1'b0;
        for (int n = 0; n < 40 && done_q !== 1'b1; n++) begin
            @(posedge clock);
            #1;
            if (bus_i.busy === 1'b1) nb++;
        end
        check(32'(nb), prcw_pkg::XFER_CYCLES);
        check(done_q, 1'b1);
        check(ready_q, 1'b0);
        if (d[prcw_pkg::DIR_TX_BIT]) begin
            x_sw[a] = s;
            x_pe[a] = p;
        end
        if (d[prcw_pkg::DIR_RX_BIT]) begin
            x_dg[a] = g;
            x_eq[a] = e;
        end
        if (d != prcw_pkg::DIR_NONE) begin
            check({bus_i.swing_out, bus_i.preemp_out, bus_i.dcgain_out, bus_i.eq_out},
                  {x_sw[a], x_pe[a], x_dg[a], x_eq[a]});
        end
        check_chans();
    endtask : do_write

    task automatic rate_cmd(input logic ok, input logic [3:0] v, input logic [3:0] exp);
        @(posedge clock);
        rate_req <= 1'b1;
        rate_val <= v;
        rate_ok  <= ok;
        @(posedge clock);
        rate_req <= 1'b0;
        #1;
        check(rate_rej_q, !ok);
        repeat (2) @(posedge clock);
        #1;
        for (int i = 0; i < NCH; i++) check(ch_rate[i], exp);
        check_chans();
    endtask : rate_cmd

    // ==========================================
    // scenarios
    task automatic t_reset;
        @(posedge clock);
        #1;
        check(bus_i.busy, 1'b0);
        check(done_q, 1'b0);
        check(ready_q, 1'b1);
        check_chans();
        check($bits(bus_i.swing_out) * 1000 + $bits(bus_i.preemp_out) * 100 + $bits(bus_i.dcgain_out) * 10
              + $bits(bus_i.eq_out), 3524);
    endtask : t_reset

    // both, then tx only so rx must survive, then rx only, then none
    task automatic t_dirs;
        for (int d = 3; d >= 0; d--) begin
            do_write(2'h2, 2'(d), 3'(d + 4), 5'(d * 7 + 3), 2'(d + 1), 4'(d * 3 + 5));
        end
    endtask : t_dirs

    task automatic t_chans;
        for (int i = 0; i < NCH; i++) begin
            do_write(2'(i), prcw_pkg::DIR_BOTH, 3'(7 - i), 5'(31 - i * 5), 2'(3 - i), 4'(15 - i * 2));
        end
    endtask : t_chans

    task automatic t_rclk;
        for (int v = 1; v >= 0; v--) begin
            @(posedge clock);
            rclk_opt <= 1'(v);
            repeat (2) @(posedge clock);
            #1;
            check(ch_own, {NCH{1'(v)}});
        end
    endtask : t_rclk

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        #20000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        {rstn, req, rate_req, rate_ok, rclk_opt, req_addr, req_dir} = '0;
        {req_sw, req_pe, req_dg, req_eq, rate_val} = '0;
        for (int i = 0; i < NCH; i++) begin
            {x_sw[i], x_pe[i], x_dg[i], x_eq[i]} = '0;
        end
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_dirs();
        t_chans();
        rate_cmd(1'b1, 4'ha, 4'ha);
        rate_cmd(1'b0, 4'h5, 4'ha);
        t_rclk();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
